// ===== hdl/byte_fifo.sv
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/100ps
module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic             clk_in,
    input  wire logic             rst_in,
    // Fill side
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    input  wire logic [WIDTH-1:0] in_data_in,
    // Drain side
    output logic                  out_valid_out,
    input  wire logic             out_ready_in,
    output logic      [WIDTH-1:0] out_data_out
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_q;
    logic [AW:0]      rd_q;
    logic             push;
    logic             pop;

    assign in_ready_out  = (wr_q - rd_q) != (AW+1)'(DEPTH);
    assign out_valid_out = wr_q != rd_q;
    assign out_data_out  = mem[rd_q[AW-1:0]];
    assign push          = in_valid_in && in_ready_out;
    assign pop           = out_valid_out && out_ready_in;

    always_ff @(posedge clk_in) begin
        if (push) begin
            mem[wr_q[AW-1:0]] <= in_data_in;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            wr_q <= '0;
        end else if (push) begin
            wr_q <= wr_q + (AW+1)'(1);
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            rd_q <= '0;
        end else if (pop) begin
            rd_q <= rd_q + (AW+1)'(1);
        end
    end
endmodule // byte_fifo

// ===== hdl/dds_cmd_ctl.sv
// Serial command interpreter driving two synthesizer modules
// Functional notes
// - Serial link fixed at 9600 baud.
// - Single-character commands; space, CR, LF terminate.
// - Only parameter commands take multi-character sequences.
// - Dedicated error output pin on command error.
// - Error sends a special serial character.
// - Prompt after command shows pending error.
// - Unique character sent after every restart.
// - Error counter increments on each error, holding at 255.
// - Commands clear errors and reboot controller.
// - Info command reports registers, fixed-length fields.
// - Second synthesizer pin usable as general output.
// - Two synthesizers, each with own reference clock.
// - Respond only to commands for own address.
// - Commands select between two synthesizer variants.
// - Short response returned for most commands.
// - Settings saved on command, restored at start.
// - Command reset reloads settings and clears errors; serial link and queue keep running.
`timescale 1ns/100ps
`include "dds_ctl_regs.svh"
module dds_cmd_ctl #(
    parameter int BAUD_DIV    = `BAUD_DIV,
    parameter int FIFO_DEPTH  = 8
) (
    // Clock and reset
    input  wire logic                     core_clk_in,
    input  wire logic                     sys_rst_in,
    // Serial link
    input  wire logic                     rx_in,
    output logic                          tx_out,
    // Indications
    output logic                          error_out,
    output logic                          gpo_out,
    // Synthesizer load port
    output dds_ctl_pkg::synth_load_t      load_out,
    // Non-volatile store
    output logic                          nv_write_out,
    output dds_ctl_pkg::settings_t        nv_data_out,
    input  wire dds_ctl_pkg::settings_t   nv_data_in
);
    // --------------------------------------------------
    // Bit timing
    // --------------------------------------------------
    function automatic logic [15:0] half_of(input int d);
        return 16'(d / 2);
    endfunction

    // --------------------------------------------------
    // Receiver
    // --------------------------------------------------
    logic [15:0] rx_cnt_q;
    logic [3:0]  rx_bit_q;
    logic [7:0]  rx_sh_q;
    logic        rx_busy_q;
    logic        rx_valid_q;
    logic        soft_rst_q;

    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            rx_cnt_q   <= 16'h0000;
            rx_bit_q   <= 4'h0;
            rx_sh_q    <= 8'h00;
            rx_busy_q  <= 1'b0;
            rx_valid_q <= 1'b0;
        end else begin
            rx_valid_q <= 1'b0;
            if (!rx_busy_q) begin
                if (!rx_in) begin
                    rx_busy_q <= 1'b1;
                    rx_cnt_q  <= half_of(BAUD_DIV);
                    rx_bit_q  <= 4'h0;
                end
            end else if (rx_cnt_q != 16'h0000) begin
                rx_cnt_q <= rx_cnt_q - 16'h0001;
            end else begin
                rx_cnt_q <= 16'(BAUD_DIV - 1);
                rx_bit_q <= rx_bit_q + 4'h1;
                if (rx_bit_q == 4'h0 && rx_in) begin
                    rx_busy_q <= 1'b0;
                end else if (rx_bit_q >= 4'h1 && rx_bit_q <= 4'h8) begin
                    rx_sh_q <= {rx_in, rx_sh_q[7:1]};
                end else if (rx_bit_q == 4'h9) begin
                    rx_busy_q  <= 1'b0;
                    rx_valid_q <= rx_in;
                end
            end
        end
    end

    // --------------------------------------------------
    // Transmit queue and transmitter
    // --------------------------------------------------
    logic       q_valid;
    logic       q_ready;
    logic [7:0] q_data;
    logic       tq_valid;
    logic       tq_ready;
    logic [7:0] tq_data;

    // Interpreter stalls while the queue is full, so no response is lost
    byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_txq (
        .clk_in        (core_clk_in),
        .rst_in        (sys_rst_in),
        .in_valid_in   (q_valid),
        .in_ready_out  (q_ready),
        .in_data_in    (q_data),
        .out_valid_out (tq_valid),
        .out_ready_in  (tq_ready),
        .out_data_out  (tq_data)
    );

    logic [15:0] tx_cnt_q;
    logic [3:0]  tx_bit_q;
    logic [9:0]  tx_sh_q;
    logic        tx_busy_q;

    assign tq_ready = !tx_busy_q;

    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            tx_cnt_q  <= 16'h0000;
            tx_bit_q  <= 4'h0;
            tx_sh_q   <= 10'h3FF;
            tx_busy_q <= 1'b0;
            tx_out    <= 1'b1;
        end else if (!tx_busy_q) begin
            tx_out <= 1'b1;
            if (tq_valid) begin
                tx_sh_q   <= {1'b1, tq_data, 1'b0};
                tx_busy_q <= 1'b1;
                tx_bit_q  <= 4'h0;
                tx_cnt_q  <= 16'h0000;
            end
        end else if (tx_cnt_q != 16'h0000) begin
            tx_cnt_q <= tx_cnt_q - 16'h0001;
        end else if (tx_bit_q == 4'hA) begin
            tx_busy_q <= 1'b0;
        end else begin
            tx_out   <= tx_sh_q[0];
            tx_sh_q  <= {1'b1, tx_sh_q[9:1]};
            tx_bit_q <= tx_bit_q + 4'h1;
            tx_cnt_q <= 16'(BAUD_DIV - 1);
        end
    end

    // --------------------------------------------------
    // Interpreter
    // --------------------------------------------------
    function automatic logic is_term(input logic [7:0] c);
        return c == `CH_SPACE || c == `CH_CR || c == `CH_LF;
    endfunction

    function automatic logic [7:0] hex_char(input logic [3:0] n);
        return (n < 4'hA) ? 8'h30 + {4'h0, n} : 8'h37 + {4'h0, n};
    endfunction

    function automatic logic is_digit(input logic [7:0] c);
        return c >= 8'h30 && c <= 8'h39;
    endfunction

    dds_ctl_pkg::ctl_state_t state_q;
    dds_ctl_pkg::settings_t  set_q;
    logic [7:0]  cmd_q;
    logic [7:0]  arg_q;
    logic [3:0]  arg_cnt_q;
    logic [31:0] num_q;
    logic        mine_q;
    logic        err_q;
    logic [7:0]  err_cnt_q;
    logic [4:0]  rep_idx_q;
    logic        bad;

    // Report stream: address, error count, flags, two frequencies
    logic [79:0] rep_word;
    assign rep_word = {set_q.addr, err_cnt_q,
                       set_q.clk_125_a, set_q.clk_125_b, set_q.variant_b,
                       set_q.one_synth, set_q.freq_a, set_q.freq_b};

    always_comb begin
        q_valid = 1'b0;
        q_data  = 8'h00;
        case (state_q)
            dds_ctl_pkg::ST_BOOT: begin
                q_valid = 1'b1;
                q_data  = `CH_BOOT;
            end
            dds_ctl_pkg::ST_EXEC: begin
                if (bad) begin
                    q_valid = 1'b1;
                    q_data  = `CH_ERROR;
                end else if (cmd_q != `CMD_INFO && cmd_q != `CMD_REBOOT) begin
                    q_valid = 1'b1;
                    q_data  = `CH_ACK;
                end
            end
            dds_ctl_pkg::ST_REPORT: begin
                q_valid = 1'b1;
                q_data  = (rep_idx_q == 5'd20) ? `CH_CR
                        : hex_char(rep_word[79 - 4*rep_idx_q -: 4]);
            end
            dds_ctl_pkg::ST_PROMPT: begin
                q_valid = 1'b1;
                q_data  = err_q ? `CH_ERR_PROMPT : `CH_PROMPT;
            end
            default: begin
                q_valid = 1'b0;
            end
        endcase
    end

    // Unknown commands and stray arguments are errors
    always_comb begin
        case (cmd_q)
            `CMD_CLR_ERR, `CMD_REBOOT, `CMD_INFO, `CMD_GPO_SET,
            `CMD_GPO_CLR, `CMD_VAR_A, `CMD_VAR_B, `CMD_SAVE,
            `CMD_CLK_100, `CMD_CLK_125, `CMD_SEL_0, `CMD_SEL_1,
            `CMD_ONE_SYNTH, `CMD_TWO_SYNTH: bad = arg_cnt_q != 4'h0;
            `CMD_ADDR: bad = arg_cnt_q != 4'h1;
            `CMD_FREQ: bad = arg_cnt_q == 4'h0;
            default:   bad = 1'b1;
        endcase
    end

    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            state_q   <= dds_ctl_pkg::ST_LOAD;
            cmd_q     <= 8'h00;
            arg_q     <= 8'h00;
            arg_cnt_q <= 4'h0;
            num_q     <= 32'h0000_0000;
            mine_q    <= 1'b0;
            rep_idx_q <= 5'd0;
            soft_rst_q <= 1'b0;
        end else begin
            soft_rst_q <= 1'b0;
            case (state_q)
                dds_ctl_pkg::ST_LOAD: state_q <= dds_ctl_pkg::ST_BOOT;
                dds_ctl_pkg::ST_BOOT: if (q_ready) state_q <= dds_ctl_pkg::ST_IDLE;
                dds_ctl_pkg::ST_IDLE: begin
                    if (rx_valid_q && !is_term(rx_sh_q)) begin
                        cmd_q     <= rx_sh_q;
                        arg_cnt_q <= 4'h0;
                        num_q     <= 32'h0000_0000;
                        state_q   <= dds_ctl_pkg::ST_ARG;
                    end
                end
                dds_ctl_pkg::ST_ARG: begin
                    if (rx_valid_q) begin
                        if (is_term(rx_sh_q)) begin
                            // Address suffix: a single argument character after the command selects the unit by its low nibble
                            mine_q  <= 1'b1;
                            state_q <= dds_ctl_pkg::ST_TERM;
                        end else begin
                            arg_q <= rx_sh_q;
                            if (arg_cnt_q != 4'hF) arg_cnt_q <= arg_cnt_q + 4'h1;
                            if (is_digit(rx_sh_q)) begin
                                num_q <= 32'(num_q * 32'd10) + {28'h0, rx_sh_q[3:0]};
                            end
                        end
                    end
                end
                dds_ctl_pkg::ST_TERM: begin
                    // Commands for another address are dropped silently
                    mine_q  <= 1'b0;
                    state_q <= (cmd_q == `CMD_ADDR || !mine_q ||
                                arg_q[3:0] == set_q.addr || arg_cnt_q != 4'h1 ||
                                cmd_q == `CMD_FREQ)
                               ? dds_ctl_pkg::ST_EXEC : dds_ctl_pkg::ST_IDLE;
                end
                dds_ctl_pkg::ST_EXEC: begin
                    if (!q_valid || q_ready) begin
                        if (!bad && cmd_q == `CMD_REBOOT) begin
                            soft_rst_q <= 1'b1;
                            state_q    <= dds_ctl_pkg::ST_LOAD;
                        end else if (!bad && cmd_q == `CMD_INFO) begin
                            rep_idx_q <= 5'd0;
                            state_q   <= dds_ctl_pkg::ST_REPORT;
                        end else if (!bad && cmd_q == `CMD_SAVE) begin
                            state_q <= dds_ctl_pkg::ST_SAVE;
                        end else begin
                            state_q <= dds_ctl_pkg::ST_PROMPT;
                        end
                    end
                end
                dds_ctl_pkg::ST_SAVE: state_q <= dds_ctl_pkg::ST_PROMPT;
                dds_ctl_pkg::ST_REPORT: begin
                    if (q_ready) begin
                        rep_idx_q <= rep_idx_q + 5'd1;
                        if (rep_idx_q == 5'd20) state_q <= dds_ctl_pkg::ST_PROMPT;
                    end
                end
                dds_ctl_pkg::ST_PROMPT: if (q_ready) state_q <= dds_ctl_pkg::ST_IDLE;
                default: state_q <= dds_ctl_pkg::ST_IDLE;
            endcase
        end
    end

    // --------------------------------------------------
    // Error tracking; a new error wins over a clear
    // --------------------------------------------------
    logic exec_go;
    assign exec_go = state_q == dds_ctl_pkg::ST_EXEC && (!q_valid || q_ready);

    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            err_q     <= 1'b0;
            err_cnt_q <= `RST_ERR_CNT;
            error_out <= 1'b0;
        end else if (soft_rst_q) begin
            err_q     <= 1'b0;
            err_cnt_q <= `RST_ERR_CNT;
            error_out <= 1'b0;
        end else if (exec_go && bad) begin
            err_q     <= 1'b1;
            error_out <= 1'b1;
            if (err_cnt_q != 8'hFF) err_cnt_q <= err_cnt_q + 8'h01;
        end else if (exec_go && cmd_q == `CMD_CLR_ERR) begin
            err_q     <= 1'b0;
            err_cnt_q <= `RST_ERR_CNT;
            error_out <= 1'b0;
        end
    end

    // --------------------------------------------------
    // Settings, synthesizer loads and store
    // --------------------------------------------------
    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            set_q        <= '0;
            load_out     <= '0;
            nv_write_out <= 1'b0;
            nv_data_out  <= '0;
            gpo_out      <= 1'b0;
        end else begin
            load_out.strobe <= 1'b0;
            nv_write_out    <= 1'b0;
            gpo_out         <= set_q.one_synth & set_q.gpo;
            if (state_q == dds_ctl_pkg::ST_LOAD) begin
                set_q <= nv_data_in;
            end else if (state_q == dds_ctl_pkg::ST_SAVE) begin
                nv_write_out <= 1'b1;
                nv_data_out  <= set_q;
            end else if (exec_go && !bad) begin
                case (cmd_q)
                    `CMD_GPO_SET:   set_q.gpo <= 1'b1;
                    `CMD_GPO_CLR:   set_q.gpo <= 1'b0;
                    `CMD_ONE_SYNTH: set_q.one_synth <= 1'b1;
                    `CMD_TWO_SYNTH: set_q.one_synth <= 1'b0;
                    `CMD_VAR_A:     set_q.variant_b <= 1'b0;
                    `CMD_VAR_B:     set_q.variant_b <= 1'b1;
                    `CMD_SEL_0:     set_q.sel_b <= 1'b0;
                    `CMD_SEL_1:     set_q.sel_b <= set_q.one_synth ? 1'b0 : 1'b1;
                    `CMD_ADDR:      set_q.addr <= arg_q[3:0];
                    `CMD_CLK_100, `CMD_CLK_125: begin
                        if (set_q.sel_b) set_q.clk_125_b <= cmd_q == `CMD_CLK_125;
                        else set_q.clk_125_a <= cmd_q == `CMD_CLK_125;
                    end
                    `CMD_FREQ: begin
                        if (set_q.sel_b) set_q.freq_b <= num_q;
                        else set_q.freq_a <= num_q;
                        load_out.strobe    <= 1'b1;
                        load_out.sel_b     <= set_q.sel_b;
                        load_out.variant_b <= set_q.variant_b;
                        load_out.clk_125   <= set_q.sel_b ? set_q.clk_125_b
                                                          : set_q.clk_125_a;
                        load_out.word      <= num_q;
                    end
                    default: set_q <= set_q;
                endcase
            end
        end
    end
endmodule // dds_cmd_ctl

// ===== shared/dds_ctl_pkg.sv
// Types for the serial synthesizer command controller
package dds_ctl_pkg;

    typedef enum logic [3:0] {
        ST_BOOT   = 4'b0000,
        ST_IDLE   = 4'b0001,
        ST_ARG    = 4'b0010,
        ST_TERM   = 4'b0011,
        ST_EXEC   = 4'b0100,
        ST_REPORT = 4'b0101,
        ST_PROMPT = 4'b0110,
        ST_LOAD   = 4'b0111,
        ST_SAVE   = 4'b1000
    } ctl_state_t;

    typedef struct packed {
        logic [3:0]  addr;
        logic        clk_125_a;
        logic        clk_125_b;
        logic        variant_b;
        logic        one_synth;
        logic        gpo;
        logic        sel_b;
        logic [31:0] freq_a;
        logic [31:0] freq_b;
    } settings_t;

    typedef struct packed {
        logic       strobe;
        logic       sel_b;
        logic       variant_b;
        logic       clk_125;
        logic [31:0] word;
    } synth_load_t;

endpackage

// ===== shared/dds_ctl_regs.svh
// Constants for the serial synthesizer command controller
`ifndef DDS_CTL_REGS_SVH
`define DDS_CTL_REGS_SVH

`define CLK_HZ          40000000
`define BAUD_RATE       9600
`define BAUD_DIV        (`CLK_HZ / `BAUD_RATE)
`define BAUD_HALF       (`BAUD_DIV / 2)

`define CH_SPACE        8'h20
`define CH_CR           8'h0D
`define CH_LF           8'h0A
`define CH_ERROR        8'h3F
`define CH_BOOT         8'h2A
`define CH_PROMPT       8'h3E
`define CH_ERR_PROMPT   8'h21
`define CH_ACK          8'h2B

`define CMD_CLR_ERR     8'h65
`define CMD_REBOOT      8'h72
`define CMD_INFO        8'h69
`define CMD_GPO_SET     8'h50
`define CMD_GPO_CLR     8'h70
`define CMD_ADDR        8'h6B
`define CMD_VAR_A       8'h35
`define CMD_VAR_B       8'h31
`define CMD_FREQ        8'h23
`define CMD_SAVE        8'h53
`define CMD_CLK_100     8'h78
`define CMD_CLK_125     8'h58
`define CMD_SEL_0       8'h61
`define CMD_SEL_1       8'h62
`define CMD_ONE_SYNTH   8'h6F
`define CMD_TWO_SYNTH   8'h74

`define RST_ADDR        4'h0
`define RST_ERR_CNT     8'h00
`define FREQ_DIGITS     8

`endif

// ===== verif/dds_ctl_monitor.sv
// Port checker for the synthesizer command controller
`timescale 1ns/100ps
module dds_ctl_monitor #(
    parameter int BAUD_DIV   = 16,
    parameter int FIFO_DEPTH = 8
) (
    // Clock and reset
    input wire logic                    core_clk_in,
    input wire logic                    sys_rst_in,
    // Serial and indications
    input wire logic                    tx_out,
    input wire logic                    error_out,
    // Load and store
    input wire dds_ctl_pkg::synth_load_t load_out,
    input wire logic                    nv_write_out
);
    // ----
    // Run length of the serial line level
    // ----
    logic [15:0] run_q;
    logic        tx_prev_q;
    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            run_q     <= 16'(BAUD_DIV);
            tx_prev_q <= 1'b1;
        end else begin
            tx_prev_q <= tx_out;
            run_q     <= (tx_out != tx_prev_q) ? 16'h0001 : run_q + {15'h0000, ~&run_q};
        end
    end
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (sys_rst_in);
    chk_reset_idle: assert property ($fell(sys_rst_in) |-> tx_out && !error_out)
        else $error("outputs not idle after reset");
    chk_strobe_pulse: assert property (load_out.strobe |=> !load_out.strobe)
        else $error("load strobe longer than one cycle");
    chk_word_held: assert property ($changed(load_out.word) |-> load_out.strobe)
        else $error("load word changed without strobe");
    chk_nv_pulse: assert property (nv_write_out |=> !nv_write_out)
        else $error("store pulse longer than one cycle");
    chk_err_reply: assert property ($rose(error_out) |-> ##[0:40] !tx_out)
        else $error("no reply after error");
    chk_clear_reply: assert property ($fell(error_out) |-> ##[0:40] !tx_out)
        else $error("no reply after error clear");
    chk_start_bit: assert property ($fell(tx_out) |-> (!tx_out) [*8])
        else $error("start bit too short");
    chk_bit_len: assert property ((tx_out != tx_prev_q) |-> run_q >= 16'(BAUD_DIV))
        else $error("serial bit shorter than bit time");
    cover property ($rose(error_out));
    cover property (load_out.strobe && load_out.sel_b);
    cover property (nv_write_out);
endmodule // dds_ctl_monitor

bind dds_cmd_ctl dds_ctl_monitor #(.BAUD_DIV(BAUD_DIV), .FIFO_DEPTH(FIFO_DEPTH)) u_mon (
    .core_clk_in  (core_clk_in),
    .sys_rst_in   (sys_rst_in),
    .tx_out       (tx_out),
    .error_out    (error_out),
    .load_out     (load_out),
    .nv_write_out (nv_write_out)
);

// ===== verif/host_term.sv
// Host terminal model: serial sender and byte collector
`timescale 1ns/100ps
module host_term #(
    parameter int BAUD_DIV = 16
) (
    // Clock
    input  wire logic clk_in,
    // Serial link
    input  wire logic line_in,
    output logic      line_out
);
    logic [7:0] rx_q[$];
    initial line_out = 1'b1;
    // Idle high, start low, LSB first, one stop bit
    task automatic send(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(negedge clk_in);
            line_out = f[i];
            repeat (BAUD_DIV - 1) @(negedge clk_in);
        end
    endtask
    // Samples mid-bit; stop bit awaited before the byte is kept
    initial begin : rx_loop
        logic [7:0] b;
        forever begin
            @(negedge line_in);
            repeat (BAUD_DIV / 2) @(posedge clk_in);
            for (int i = 0; i < 8; i++) begin
                repeat (BAUD_DIV) @(posedge clk_in);
                b[i] = line_in;
            end
            repeat (BAUD_DIV) @(posedge clk_in);
            rx_q.push_back(b);
        end
    end
endmodule // host_term

// ===== verif/tb_top.sv
// Self-checking bench for the synthesizer command controller
`timescale 1ns/100ps
`include "dds_ctl_regs.svh"
module tb_top;
    localparam int DIV = 16;
    logic                     core_clk_in = 1'b0;
    logic                     sys_rst_in  = 1'b1;
    logic                     rx_line;
    logic                     tx_out;
    logic                     error_out;
    logic                     gpo_out;
    logic                     nv_write_out;
    dds_ctl_pkg::synth_load_t load_out;
    dds_ctl_pkg::synth_load_t ld_q;
    dds_ctl_pkg::settings_t   nv_data_out;
    dds_ctl_pkg::settings_t   nv_data_in;
    dds_ctl_pkg::settings_t   nv_q;
    int n_mismatch = 0;
    int tests_run  = 0;
    int cycles     = 0;
    int ld_cnt     = 0;
    int nv_cnt     = 0;
    always #12.5 core_clk_in = ~core_clk_in;
    dds_cmd_ctl #(.BAUD_DIV(DIV), .FIFO_DEPTH(8)) dut (
        .core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in), .rx_in(rx_line),
        .tx_out(tx_out), .error_out(error_out), .gpo_out(gpo_out), .load_out(load_out),
        .nv_write_out(nv_write_out), .nv_data_out(nv_data_out), .nv_data_in(nv_data_in));
    host_term #(.BAUD_DIV(DIV)) host (.clk_in(core_clk_in), .line_in(tx_out), .line_out(rx_line));
    // ----
    // Capture of pulses and hang limit
    // ----
    always @(posedge core_clk_in) begin
        cycles <= cycles + 1;
        if (load_out.strobe === 1'b1) begin
            ld_cnt <= ld_cnt + 1;
            ld_q   <= load_out;
        end
        if (nv_write_out === 1'b1) begin
            nv_cnt <= nv_cnt + 1;
            nv_q   <= nv_data_out;
        end
        if (cycles == 60000) begin
            n_mismatch++;
            finish_test();
        end
    end
    // ----
    // Shared tasks
    // ----
    task automatic finish_test;
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic expect_b(input logic [7:0] e);
        logic [7:0] b;
        for (int i = 0; i < 3000 && host.rx_q.size() == 0; i++) @(posedge core_clk_in);
        b = (host.rx_q.size() > 0) ? host.rx_q.pop_front() : 'x;
        check(b, e);
    endtask
    task automatic cmd(input string s, input logic [7:0] t, input logic [7:0] r);
        for (int i = 0; i < s.len(); i++) host.send(8'(s[i]));
        host.send(t);
        expect_b(r);
        if (r != `CH_BOOT) expect_b(r == `CH_ERROR ? `CH_ERR_PROMPT : `CH_PROMPT);
    endtask
    // ----
    // Scenarios
    // ----
    task automatic t_boot;
        expect_b(`CH_BOOT);
        check(gpo_out, 1'b1);
    endtask
    task automatic t_bad;
        cmd("Z", `CH_CR, `CH_ERROR);
        check(error_out, 1'b1);
    endtask
    task automatic t_info;
        host.send(`CMD_INFO);
        host.send(`CH_LF);
        expect_b(8'h33);
        expect_b(8'h30);
        expect_b(8'h31);
        expect_b(8'h31);
        for (int i = 0; i < 16; i++) expect_b(8'h30);
        expect_b(`CH_CR);
        expect_b(`CH_ERR_PROMPT);
    endtask
    task automatic t_clear;
        cmd("e", `CH_SPACE, `CH_ACK);
        check(error_out, 1'b0);
    endtask
    task automatic t_gpo;
        cmd("p", `CH_CR, `CH_ACK);
        check(gpo_out, 1'b0);
        cmd("P", `CH_LF, `CH_ACK);
        check(gpo_out, 1'b1);
        cmd("t", `CH_SPACE, `CH_ACK);
        check(gpo_out, 1'b0);
        cmd("o", `CH_SPACE, `CH_ACK);
        check(gpo_out, 1'b1);
        // Argument nibble names another unit: no reply, no effect
        host.send(`CMD_GPO_CLR);
        host.send(8'h35);
        host.send(`CH_CR);
        repeat (400) @(posedge core_clk_in);
        check(host.rx_q.size(), 0);
        check(gpo_out, 1'b1);
    endtask
    task automatic t_reboot;
        cmd("p", `CH_SPACE, `CH_ACK);
        cmd("Z", `CH_SPACE, `CH_ERROR);
        cmd("r", `CH_SPACE, `CH_BOOT);
        check(error_out, 1'b0);
        check(gpo_out, 1'b1);
        repeat (400) @(posedge core_clk_in);
        host.rx_q.delete();
    endtask
    task automatic t_freq;
        // Second synthesizer is only selectable in two-synthesizer mode
        cmd("t", `CH_SPACE, `CH_ACK);
        cmd("1", `CH_SPACE, `CH_ACK);
        cmd("b", `CH_SPACE, `CH_ACK);
        cmd("X", `CH_SPACE, `CH_ACK);
        cmd("#25", `CH_CR, `CH_ACK);
        check(ld_cnt, 1);
        check({ld_q.sel_b, ld_q.clk_125, ld_q.variant_b}, 3'h7);
        check(ld_q.word, 32'h19);
        cmd("o", `CH_SPACE, `CH_ACK);
        cmd("5", `CH_SPACE, `CH_ACK);
        cmd("a", `CH_SPACE, `CH_ACK);
        cmd("#7", `CH_LF, `CH_ACK);
        check(ld_cnt, 2);
        check({ld_q.sel_b, ld_q.clk_125, ld_q.variant_b}, 3'h0);
        check(ld_q.word, 32'h7);
    endtask
    task automatic t_save;
        cmd("S", `CH_SPACE, `CH_ACK);
        check(nv_cnt, 1);
        check({nv_q.one_synth, nv_q.gpo, nv_q.variant_b, nv_q.clk_125_b}, 4'hD);
        check(nv_q.freq_b, 32'h19);
    endtask
    initial begin
        nv_data_in           = '0;
        nv_data_in.addr      = 4'h3;
        nv_data_in.one_synth = 1'b1;
        nv_data_in.gpo       = 1'b1;
        repeat (5) @(negedge core_clk_in);
        sys_rst_in = 1'b0;
        t_boot();
        t_bad();
        t_info();
        t_clear();
        t_gpo();
        t_reboot();
        t_freq();
        t_save();
        finish_test();
    end
endmodule // tb_top
